// >>> core/rdb_pkg.sv
// package: constants, kinds and carriers for the resync dc balance selector
package rdb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes and counts
    localparam int SUM_W      = 24;
    localparam int BUF_DEPTH  = 2048;
    localparam int BUF_AW     = 11;
    localparam int CNT_W      = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int STEP_W     = 6;
    localparam logic [STEP_W-1:0] LAST_BLOCK = 6'h27;

    ////////////////////////////////////////////////////////////////////////////
    // resync pattern, msb sent first; the x position is excluded by the mask
    localparam int             RS_LEN     = 19;
    localparam int             RS_POS_W   = 5;
    localparam logic [18:0]    RS_PATTERN = 19'h08102;
    localparam logic [18:0]    RS_CARE    = 19'h5FFFF;
    localparam logic           FLIP_A_LEAD = 1'h0;
    localparam logic           FLIP_B_LEAD = 1'h1;

    ////////////////////////////////////////////////////////////////////////////
    // segment kinds and state
    typedef enum logic [1:0] {
        KIND_HEAD   = 2'h0,
        KIND_RESYNC = 2'h1,
        KIND_FLIP   = 2'h2,
        KIND_BLOCK  = 2'h3
    } rdb_kind_e;

    typedef enum logic [2:0] {
        ST_PASS  = 3'h1,
        ST_FILL  = 3'h2,
        ST_DRAIN = 3'h4
    } rdb_state_e;

    typedef struct packed {
        logic      bit_val;
        rdb_kind_e kind;
        logic      field_start;
        logic      field_end;
    } rdb_in_s;

    typedef struct packed {
        logic bit_val;
        logic flip_lead;
        logic field_end;
    } rdb_out_s;

    localparam int OUT_W = $bits(rdb_out_s);

endpackage : rdb_pkg

// >>> core/rdb_fifo.sv
// fifo between the selector core and the output stage
`timescale 1ns/1ns
module rdb_fifo
    import rdb_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // fill side
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    logic             do_wr;
    logic             do_rd;

    assign wr_ready = (fill != DEPTH[AW:0]);
    assign rd_valid = (fill != '0);
    assign rd_data  = mem[rd_ptr];
    assign do_wr    = wr_valid && wr_ready;
    assign do_rd    = rd_valid && rd_ready;

    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            fill <= fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    chk_fill_bound: assert property (@(posedge clock) disable iff (rst) fill <= DEPTH[AW:0])
        else $error("fifo fill above depth");

endmodule : rdb_fifo

// >>> core/rdb_selector.sv
// resync flip-part selector that keeps the channel-bit running sum near zero
`timescale 1ns/1ns
module rdb_selector
    import rdb_pkg::*;
(
    // clock and reset
    input  wire logic    clock,
    input  wire logic    rst,
    // from the sector formatter
    input  wire logic    in_valid,
    input  wire rdb_in_s in_data,
    output logic         in_ready,
    // to the write channel
    output logic         out_valid,
    output rdb_out_s     out_data,
    input  wire logic    out_ready,
    // status
    output logic signed [SUM_W-1:0] running_digital_sum,
    output logic         last_choice_b,
    output logic         pattern_error,
    output logic         order_error,
    output logic         overflow
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic signed [SUM_W-1:0] level_step(input logic lv);
        level_step = lv ? SUM_W'(1) : -SUM_W'(1);
    endfunction : level_step

    function automatic logic signed [SUM_W-1:0] mag(input logic signed [SUM_W-1:0] v);
        mag = v[SUM_W-1] ? -v : v;
    endfunction : mag

    ////////////////////////////////////////////////////////////////////////////
    // input holding register; ready is registered so it trades half rate for timing
    rdb_in_s hold;
    logic    hold_full;
    logic    consume;
    logic    take;

    assign take = in_valid && in_ready;

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_full <= 1'b0;
            in_ready  <= 1'b0;
        end else begin
            hold_full <= take || (hold_full && !consume);
            in_ready  <= !(take || (hold_full && !consume));
        end
    end

    always_ff @(posedge clock) begin
        if (take) begin
            hold <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core state
    rdb_state_e                 st;
    logic                       lvl;
    logic                       tlev;
    logic signed [SUM_W-1:0]    sum_a;
    logic [CNT_W-1:0]           cnt;
    logic [CNT_W-1:0]           rd;
    logic                       seen_body;
    logic                       fin;
    logic                       sel_b;
    logic [STEP_W-1:0]          step;
    logic [RS_POS_W-1:0]        rs_pos;
    logic                       buf_mem [BUF_DEPTH];

    logic                       fifo_ready;
    logic                       push;
    rdb_out_s                   push_data;
    logic                       pass_take;
    logic                       fill_take;
    logic                       decide;
    logic                       drain_last;
    logic signed [SUM_W-1:0]    cand_a;
    logic signed [SUM_W-1:0]    cand_b;
    logic                       pick_b;
    logic                       stored_bit;
    logic                       next_tlev;
    logic                       next_lvl;

    assign pass_take  = (st == ST_PASS) && hold_full && (hold.kind != KIND_FLIP) && fifo_ready;
    assign fill_take  = (st == ST_FILL) && hold_full && !fin
                        && !((hold.kind == KIND_FLIP) && seen_body);
    assign decide     = (st == ST_FILL) && (fin || (hold_full && (hold.kind == KIND_FLIP) && seen_body));
    assign consume    = pass_take || fill_take;
    assign drain_last = (rd == cnt - 1'b1);

    // candidate b only adds a toggle at its lead bit, so its whole segment sum is the negation
    assign cand_a = running_digital_sum + sum_a;
    assign cand_b = running_digital_sum - sum_a;
    assign pick_b = mag(cand_a) > mag(cand_b);

    // flip lead bit is forced to variant a while buffering; trailing bits pass as encoded
    assign stored_bit = ((hold.kind == KIND_FLIP) && !seen_body && (cnt == '0)) ? FLIP_A_LEAD
                        : hold.bit_val;
    assign next_tlev  = tlev ^ stored_bit;
    assign next_lvl   = (hold.field_start ? 1'b0 : lvl) ^ hold.bit_val;

    always_comb begin
        push      = 1'b0;
        push_data = '0;
        if (pass_take) begin
            push              = 1'b1;
            push_data.bit_val = hold.bit_val;
        end else if ((st == ST_DRAIN) && fifo_ready) begin
            push                = 1'b1;
            push_data.flip_lead = (rd == '0);
            push_data.bit_val   = (rd == '0) ? (sel_b ? FLIP_B_LEAD : FLIP_A_LEAD) : buf_mem[rd[BUF_AW-1:0]];
            push_data.field_end = fin && drain_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= ST_PASS;
        end else begin
            unique case (st)
                ST_PASS: begin
                    if (hold_full && (hold.kind == KIND_FLIP)) begin
                        st <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (decide) begin
                        st <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (fifo_ready && drain_last) begin
                        st <= fin ? ST_PASS : ST_FILL;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cumulative sum and level
    always_ff @(posedge clock) begin
        if (rst) begin
            running_digital_sum <= '0;
            lvl                 <= 1'b0;
            sel_b               <= 1'b0;
        end else if (pass_take) begin
            lvl                 <= next_lvl;
            running_digital_sum <= (hold.field_start ? '0 : running_digital_sum) + level_step(next_lvl);
        end else if (decide) begin
            sel_b               <= pick_b;
            running_digital_sum <= pick_b ? cand_b : cand_a;
            lvl                 <= tlev ^ pick_b;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            last_choice_b <= 1'b0;
        end else if (decide) begin
            last_choice_b <= pick_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // segment buffer and candidate sum
    always_ff @(posedge clock) begin
        if (fill_take && (cnt < CNT_W'(BUF_DEPTH))) begin
            buf_mem[cnt[BUF_AW-1:0]] <= stored_bit;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tlev      <= 1'b0;
            sum_a     <= '0;
            cnt       <= '0;
            seen_body <= 1'b0;
            fin       <= 1'b0;
            rd        <= '0;
        end else if ((st == ST_PASS) && hold_full && (hold.kind == KIND_FLIP)) begin
            tlev      <= lvl;
            sum_a     <= '0;
            cnt       <= '0;
            seen_body <= 1'b0;
        end else if (fill_take) begin
            tlev      <= next_tlev;
            sum_a     <= sum_a + level_step(next_tlev);
            cnt       <= (cnt < CNT_W'(BUF_DEPTH)) ? cnt + 1'b1 : cnt;
            seen_body <= seen_body || (hold.kind != KIND_FLIP);
            fin       <= hold.field_end;
        end else if (decide) begin
            rd <= '0;
        end else if ((st == ST_DRAIN) && fifo_ready) begin
            rd <= rd + 1'b1;
            if (drain_last) begin
                tlev      <= lvl;
                sum_a     <= '0;
                cnt       <= '0;
                seen_body <= 1'b0;
                fin       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field checks: resync pattern, step count, buffer room
    always_ff @(posedge clock) begin
        if (rst) begin
            rs_pos        <= '0;
            pattern_error <= 1'b0;
            step          <= '0;
            order_error   <= 1'b0;
            overflow      <= 1'b0;
        end else begin
            if (consume) begin
                rs_pos <= (hold.kind == KIND_RESYNC) ? rs_pos + 1'b1 : '0;
                if ((hold.kind == KIND_RESYNC) && (rs_pos < RS_POS_W'(RS_LEN))
                    && RS_CARE[RS_LEN-1-rs_pos]
                    && (hold.bit_val != RS_PATTERN[RS_LEN-1-rs_pos])) begin
                    pattern_error <= 1'b1;
                end
            end
            if (pass_take && hold.field_start) begin
                step <= '0;
            end else if (decide) begin
                step <= step + 1'b1;
                if ((step >= LAST_BLOCK) || (fin && (step != LAST_BLOCK - 1'b1))) begin
                    order_error <= 1'b1;
                end
            end
            if (fill_take && (cnt == CNT_W'(BUF_DEPTH))) begin
                overflow <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output fifo and registered output stage
    logic     fifo_rd_valid;
    rdb_out_s fifo_rd_data;
    logic     fifo_pop;

    assign fifo_pop = fifo_rd_valid && (!out_valid || out_ready);

    rdb_fifo #(
        .WIDTH (OUT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rst      (rst),
        .wr_valid (push),
        .wr_ready (fifo_ready),
        .wr_data  (push_data),
        .rd_valid (fifo_rd_valid),
        .rd_ready (fifo_pop),
        .rd_data  (fifo_rd_data)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (!out_valid || out_ready) begin
            out_valid <= fifo_rd_valid;
            out_data  <= fifo_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_decide;
        decide;
    endsequence

    sequence s_drain_start;
        (st == ST_DRAIN) && (rd == '0);
    endsequence

    chk_tie_pick_a: assert property (@(posedge clock) disable iff (rst)
        decide && (mag(cand_a) == mag(cand_b)) |=> !sel_b)
        else $error("tie did not pick variant a");

    chk_pick_smaller: assert property (@(posedge clock) disable iff (rst)
        s_decide |=> (mag(running_digital_sum) <= mag($past(cand_a)))
                  && (mag(running_digital_sum) <= mag($past(cand_b))))
        else $error("chosen sum not the smaller one");

    chk_level_carry: assert property (@(posedge clock) disable iff (rst)
        s_decide |=> lvl == ($past(tlev) ^ sel_b))
        else $error("level not carried across segment");

    chk_level_toggle: assert property (@(posedge clock) disable iff (rst)
        pass_take && !hold.field_start && hold.bit_val |=> lvl != $past(lvl))
        else $error("one bit did not toggle level");

    chk_sum_step: assert property (@(posedge clock) disable iff (rst)
        pass_take && !hold.field_start |=> running_digital_sum == $past(running_digital_sum) + level_step(lvl))
        else $error("sum step wrong");

    chk_start_clear: assert property (@(posedge clock) disable iff (rst)
        pass_take && hold.field_start |=> mag(running_digital_sum) == SUM_W'(1))
        else $error("sum not cleared at field start");

    chk_flip_lead: assert property (@(posedge clock) disable iff (rst)
        push && push_data.flip_lead |-> push_data.bit_val == sel_b)
        else $error("flip lead bit disagrees with choice");

    chk_step_limit: assert property (@(posedge clock) disable iff (rst)
        decide && (step >= LAST_BLOCK) |=> order_error)
        else $error("step past last block not flagged");

    chk_drain_follow: assert property (@(posedge clock) disable iff (rst)
        s_decide |=> s_drain_start)
        else $error("drain did not follow decision");

    chk_seed_fill: assert property (@(posedge clock) disable iff (rst)
        (st == ST_PASS) && hold_full && (hold.kind == KIND_FLIP) |=> (sum_a == '0) && (tlev == lvl))
        else $error("segment sum not seeded from head");

endmodule : rdb_selector

// >>> test/rdb_formatter_model.sv
// behavioural sector formatter that hands channel bits to the selector one per handshake
`timescale 1ns/1ns
module rdb_formatter_model
    import rdb_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // channel bits to the selector
    output logic      in_valid,
    output rdb_in_s   in_data,
    input  wire logic in_ready
);
    rdb_in_s q[$];
    int      gap = 0;

    ////////////////////////////////////////////////////////////////////////////
    task automatic push(input rdb_in_s w);
        q.push_back(w);
    endtask : push

    ////////////////////////////////////////////////////////////////////////////
    // request held until in_ready is sampled high; a released bit line shows the inverse
    // so a stale value can never pass for fresh data
    initial begin
        in_valid = 1'h0;
        in_data  = '0;
        forever begin
            @(posedge clock);
            #1;
            if (!rst && q.size() > 0) begin
                in_valid = 1'h1;
                in_data  = q[0];
                @(posedge clock);
                while (in_ready !== 1'h1 && !rst) @(posedge clock);
                if (!rst) begin
                    void'(q.pop_front());
                end
                #1;
                in_valid        = 1'h0;
                in_data.bit_val = ~in_data.bit_val;
                repeat (gap) @(posedge clock);
            end
        end
    end
endmodule : rdb_formatter_model

// >>> test/tb.sv
// self-checking bench for the resync flip-part selector
`timescale 1ns/1ns
module tb
    import rdb_pkg::*;
;
    logic                    clock, rst, out_ready = 1'h0, stall_on, in_valid, in_ready, out_valid;
    rdb_in_s                 in_data;
    rdb_out_s                out_data;
    logic signed [SUM_W-1:0] running_digital_sum;
    logic                    last_choice_b, pattern_error, order_error, overflow;
    logic [15:0]             cyc = 16'h0;
    rdb_out_s                ob[$];
    logic                    sb[0:4095];
    logic                    isl[0:4095];
    int                      n, pexp, err_total, total_checks;
    logic                    bexp;

    rdb_selector rdb_selector_inst (.clock(clock), .rst(rst), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .running_digital_sum(running_digital_sum), .last_choice_b(last_choice_b),
        .pattern_error(pattern_error), .order_error(order_error), .overflow(overflow));
    rdb_formatter_model rdb_formatter_model_inst (.clock(clock), .rst(rst), .in_valid(in_valid),
        .in_data(in_data), .in_ready(in_ready));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    // write channel: stalls half of every 32 cycles when asked, so the fifo fills
    always @(posedge clock) begin
        cyc <= cyc + 16'h1;
        out_ready <= #1 !(stall_on && cyc[4]);
        if (!rst && out_valid && out_ready) begin
            ob.push_back(out_data);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic do_reset();
        rst = 1'h1;
        rdb_formatter_model_inst.q.delete();
        repeat (6) @(posedge clock);
        #1;
        check("ready in reset", in_ready, 0);
        check("valid in reset", out_valid, 0);
        check("sum in reset", {8'h0, running_digital_sum}, 0);
        rst = 1'h0;
        ob.delete();
        n = 0;
        @(posedge clock);
        #1;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    task automatic add(input logic b, input rdb_kind_e k, input logic lead, input logic st, input logic en);
        rdb_in_s w;
        w = '{bit_val: b, kind: k, field_start: st, field_end: en};
        sb[n]  = b;
        isl[n] = lead;
        n++;
        rdb_formatter_model_inst.push(w);
    endtask : add

    task automatic add_rs(input logic xbit, input logic bad);
        for (int i = 18; i >= 0; i--) begin
            add((i == 17) ? xbit : (RS_PATTERN[i] ^ (bad && i == 5)), KIND_RESYNC, 0, 0, 0);
        end
    endtask : add_rs

    // field: head, resync, then flip + block + resync per step, last step without resync
    task automatic build(input int blen, pat, last, bad, input logic xbit);
        for (int i = 0; i < 8; i++) add(i % 3 == 0, KIND_HEAD, 0, i == 0, 0);
        add_rs(xbit, 0);
        for (int m = 1; m <= last; m++) begin
            add(0, KIND_FLIP, 1, 0, 0);
            add(0, KIND_FLIP, 0, 0, 0);
            add(0, KIND_FLIP, 0, 0, 0);
            add(m % 2, KIND_FLIP, 0, 0, 0);
            for (int i = 0; i < blen; i++) add(((m * 5 + i * pat) % 7) < 2, KIND_BLOCK, 0, 0,
                m == last && i == blen - 1);
            if (m != last) add_rs(xbit, m == bad);
        end
    endtask : build

    function automatic int seg(input int s, input logic lead, input logic lv);
        int d = 0;
        for (int j = s; j < n && (j == s || !isl[j]); j++) begin
            if (j == s ? lead : sb[j]) lv = ~lv;
            d += lv ? 1 : -1;
        end
        return d;
    endfunction : seg

    function automatic int mag(input int v);
        return (v < 0) ? -v : v;
    endfunction : mag

    task automatic run_field(input int blen, pat, last, bad, input logic xbit);
        logic lv;
        build(blen, pat, last, bad, xbit);
        lv = 0;
        pexp = 0;
        bexp = 0;
        for (int i = 0; i < n; i++) begin
            if (isl[i]) begin
                bexp = mag(pexp + seg(i, 1, lv)) < mag(pexp + seg(i, 0, lv));
                sb[i] = bexp;
            end
            if (sb[i]) lv = ~lv;
            pexp += lv ? 1 : -1;
        end
        for (int t = 0; t < 12000 && ob.size() < n; t++) @(posedge clock);
        repeat (20) @(posedge clock);
        #1;
    endtask : run_field

    task automatic verify_stream();
        check("out count", ob.size(), n);
        for (int i = 0; i < n && i < ob.size(); i++) begin
            check("out bit", ob[i].bit_val, sb[i]);
            check("flip lead", ob[i].flip_lead, isl[i]);
            check("field end", ob[i].field_end, i == n - 1);
        end
        check("sum", {8'h0, running_digital_sum}, {8'h0, pexp[SUM_W-1:0]});
        check("last choice", last_choice_b, bexp);
        check("overflow", overflow, 0);
        check("order flag", order_error, 0);
    endtask : verify_stream

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_plain();
        do_reset();
        run_field(16, 3, 39, 0, 1'h1);
        verify_stream();
        check("pattern flag x", pattern_error, 0);
        $display("test plain done");
    endtask : t_plain

    task automatic t_stall();
        do_reset();
        stall_on = 1'h1;
        rdb_formatter_model_inst.gap = 1;
        run_field(9, 0, 39, 0, 1'h0);
        verify_stream();
        stall_on = 1'h0;
        rdb_formatter_model_inst.gap = 0;
        $display("test stall done");
    endtask : t_stall

    task automatic t_bad_resync();
        do_reset();
        run_field(4, 1, 39, 7, 1'h0);
        check("pattern flag", pattern_error, 1);
        $display("test bad resync done");
    endtask : t_bad_resync

    task automatic t_short();
        do_reset();
        run_field(4, 1, 20, 0, 1'h0);
        check("order flag short", order_error, 1);
        check("pattern flag short", pattern_error, 0);
        $display("test short field done");
    endtask : t_short

    // one decision too many: the fortieth step must raise the order flag
    task automatic t_long();
        do_reset();
        run_field(4, 1, 40, 0, 1'h0);
        check("order flag long", order_error, 1);
        check("pattern flag long", pattern_error, 0);
        $display("test long field done");
    endtask : t_long

    // a segment longer than the buffer must raise the sticky overflow flag
    task automatic t_overflow();
        do_reset();
        run_field(2100, 1, 1, 0, 1'h0);
        check("overflow flag", overflow, 1);
        check("pattern flag ovf", pattern_error, 0);
        $display("test overflow done");
    endtask : t_overflow

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'h1;
        stall_on = 1'h0;
        err_total = 0;
        total_checks = 0;
        t_plain();
        t_stall();
        t_bad_resync();
        t_short();
        t_long();
        t_overflow();
        close_out();
    end

    initial begin
        #(40 * 90000);
        err_total++;
        close_out();
    end
endmodule : tb
